// >>> rtl/ctrl_rx_logic.sv
// ctrl_rx_logic: receiver trip/guard/low-level qualification for 3-frequency programs
// assumes indications and switches are synchronous to clk; switches static in service
// Overview of operation
// - trip only after continuous pretrip delay
// - transfer trip pretrip 2 to 30 ms
// - binary weights 2/4/8/16, zero gives 2
// - trip hold stretches trip output
// - permissive trip hold field decode
// - transfer trip hold separate field
// - guard hold stretches guard output
// - permissive guard hold field decode
// - transfer trip guard hold own field
// - loss of channel opens unblock window
// - unblock window 150/300/500 ms decode
// - noise block suppresses unblock window
// - guard-before-trip needs 120 ms guard
// - override after 1000 ms trip or channel loss
// - guard-before-trip mode field decode
// - low-level delay postpones window and output
// - low-level delay 50/75/100 ms decode
// - permissive pretrip 0 to 30 ms
`timescale 1ns/1ps
`default_nettype none
module ctrl_rx_logic
  import ctrl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
)(
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire logic      ce,
  input  wire ctrl_ind_s ind,
  input  wire ctrl_sw_s  sw,
  output ctrl_out_s      out
);
  logic [17:0]  tick_cnt_r;
  logic         tick_r;
  ctrl_sw_s     sw_r;
  logic [9:0]   pre_cnt_r;
  logic [9:0]   guard_cnt_r;
  logic [9:0]   tlong_cnt_r;
  logic [9:0]   ll_cnt_r;
  logic [9:0]   win_cnt_r;
  logic         loc_d_r;
  logic         trip_q_r;
  logic         ll_q_r;
  ctrl_out_s    out_r;
  logic         trip_st;
  logic         guard_st;

  // ms timebase
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end
    else if (ce)
    begin
      tick_r     <= (tick_cnt_r == 18'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 18'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // switches registered; also loaded in reset so the first cycle after release
  // never decodes an all-open image (zero pretrip would let a held trip through)
  always_ff @(posedge clk)
  begin
    if (!rst_b || ce)
      sw_r <= sw;
  end

  function automatic logic [9:0] hold_ms(input logic [1:0] s);
    unique case (s)
      2'h0: hold_ms = 10'h000;
      2'h1: hold_ms = HOLD_10_MS;
      2'h2: hold_ms = HOLD_50_MS;
      2'h3: hold_ms = HOLD_100_MS;
    endcase
  endfunction

  wire       direct_transfer_trip_scheme         = sw_r.dtt_scheme;
  wire [3:0] pre_code    = direct_transfer_trip_scheme ? sw_r.dtt_pretrip : sw_r.pretrip;
  // zero code in transfer trip still means one 2 ms step
  wire [9:0] pre_ms      = (direct_transfer_trip_scheme && pre_code == 4'h0) ? PRETRIP_STEP_MS
                         : 10'(pre_code) * PRETRIP_STEP_MS;
  wire [1:0] th_sel      = direct_transfer_trip_scheme ? sw_r.dtt_trip_hold_sel : sw_r.trip_hold_sel;
  wire [1:0] gh_sel      = direct_transfer_trip_scheme ? sw_r.dtt_guard_hold_sel : sw_r.guard_hold_sel;
  wire [9:0] th_ms       = hold_ms(th_sel);
  wire [9:0] gh_ms       = hold_ms(gh_sel);
  wire [9:0] unblk_ms    = (sw_r.unblock_time_sel == 2'h1) ? UNBLK_150_MS
                         : (sw_r.unblock_time_sel == 2'h2) ? UNBLK_300_MS
                         : (sw_r.unblock_time_sel == 2'h3) ? UNBLK_500_MS : 10'h000;
  wire [9:0] ll_ms       = (sw_r.low_level_delay_sel == 2'h1) ? LOWLVL_50_MS
                         : (sw_r.low_level_delay_sel == 2'h2) ? LOWLVL_75_MS
                         : (sw_r.low_level_delay_sel == 2'h3) ? LOWLVL_100_MS : 10'h000;
  wire ctrl_gbt_e gbt    = (sw_r.guard_before_trip_sel == 2'h1) ? CTRL_GBT_NO_OVRD
                         : (sw_r.guard_before_trip_sel == 2'h2) ? CTRL_GBT_OVRD : CTRL_GBT_OFF;

  wire loc_raw   = ind.low_level && !ind.guard;
  wire ll_done   = (ll_ms == 10'h000) || (ll_cnt_r >= ll_ms);
  wire loc_dly   = loc_raw && ll_done;
  wire ll_dly    = ind.low_level && ll_done;
  wire win_open  = (win_cnt_r != 10'h000) && !(sw_r.noise_block_sel && ind.noise);
  wire pre_done  = (pre_ms == 10'h000) || (pre_cnt_r >= pre_ms);
  wire guard_ok  = guard_cnt_r >= GBT_GUARD_MS;
  wire tlong     = tlong_cnt_r > GBT_OVRD_MS;
  wire gbt_pass  = (gbt == CTRL_GBT_OFF)
                || guard_ok
                || (gbt == CTRL_GBT_OVRD && (tlong || loc_dly));
  // permissive trip needs the window when channel is lost
  wire trip_q    = ind.trip && pre_done && gbt_pass
                && (!loc_raw || unblk_ms == 10'h000 || win_open || !ll_done);

  function automatic logic [9:0] run(input logic c, input logic [9:0] v, input logic t);
    run = !c ? 10'h000 : ((t && v != 10'h3ff) ? v + 1'b1 : v);
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pre_cnt_r   <= '0;
      guard_cnt_r <= '0;
      tlong_cnt_r <= '0;
      ll_cnt_r    <= '0;
      win_cnt_r   <= '0;
      loc_d_r     <= 1'b0;
      trip_q_r    <= 1'b0;
      ll_q_r      <= 1'b0;
    end
    else if (ce)
    begin
      pre_cnt_r   <= run(ind.trip, pre_cnt_r, tick_r);
      // guard memory is kept while trip follows, so it counts guard before trip
      guard_cnt_r <= ind.guard ? run(1'b1, guard_cnt_r, tick_r)
                   : (ind.trip ? guard_cnt_r : 10'h000);
      tlong_cnt_r <= run(ind.trip, tlong_cnt_r, tick_r);
      ll_cnt_r    <= run(ind.low_level, ll_cnt_r, tick_r);
      loc_d_r     <= loc_dly;
      if (loc_dly && !loc_d_r && unblk_ms != 10'h000)
        win_cnt_r <= unblk_ms;
      else if (tick_r && win_cnt_r != 10'h000)
        win_cnt_r <= win_cnt_r - 1'b1;
      trip_q_r    <= trip_q;
      ll_q_r      <= ll_dly;
    end
  end

  ctrl_stretch #(.W(MS_W)) u_trip_hold (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .tick  (tick_r),
    .in    (trip_q_r),
    .len   (th_ms),
    .out   (trip_st)
  );

  ctrl_stretch #(.W(MS_W)) u_guard_hold (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .tick  (tick_r),
    .in    (ind.guard),
    .len   (gh_ms),
    .out   (guard_st)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      out_r <= '0;
    else if (ce)
    begin
      out_r.trip      <= trip_st;
      out_r.guard     <= guard_st;
      out_r.low_level <= ll_q_r;
    end
  end
  assign out = out_r;

  // assertions
  a_trip_needs_pre: assert property (@(posedge clk) disable iff (!rst_b)
    trip_q_r |-> (pre_ms == 10'h000 || pre_cnt_r >= pre_ms || $past(pre_cnt_r) >= pre_ms))
    else $error("trip qualified before pretrip delay");
  a_dtt_pre_min: assert property (@(posedge clk) disable iff (!rst_b)
    direct_transfer_trip_scheme |-> (pre_ms >= 10'h002 && pre_ms <= 10'h01e))
    else $error("transfer trip pretrip out of range");
  a_dtt_zero_code: assert property (@(posedge clk) disable iff (!rst_b)
    (direct_transfer_trip_scheme && sw_r.dtt_pretrip == 4'h0) |-> pre_ms == 10'h002)
    else $error("transfer trip zero code not 2 ms");
  a_perm_pre_scale: assert property (@(posedge clk) disable iff (!rst_b)
    !direct_transfer_trip_scheme |-> pre_ms == {5'h00, sw_r.pretrip, 1'b0})
    else $error("permissive pretrip scale wrong");
  a_hold_follows: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (th_ms == 10'h000 && !trip_q_r && $stable(th_ms)) |=> !trip_st)
    else $error("trip stretched with hold disabled");
  a_trip_hold_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (direct_transfer_trip_scheme && sw_r.dtt_trip_hold_sel == 2'h2) |-> th_ms == 10'h032)
    else $error("transfer trip hold decode wrong");
  a_perm_trip_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (!direct_transfer_trip_scheme && sw_r.trip_hold_sel == 2'h1) |-> th_ms == 10'h00a)
    else $error("permissive trip hold decode wrong");
  a_guard_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (gh_sel == 2'h3) |-> gh_ms == 10'h064)
    else $error("guard hold decode wrong");
  a_unblk_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (sw_r.unblock_time_sel == 2'h3) |-> unblk_ms == 10'h1f4)
    else $error("unblock decode wrong");
  a_noise_block: assert property (@(posedge clk) disable iff (!rst_b)
    (sw_r.noise_block_sel && ind.noise && loc_raw && ll_done && unblk_ms != 10'h000) |-> !trip_q)
    else $error("noise did not block unblock trip");
  a_gbt_guard: assert property (@(posedge clk) disable iff (!rst_b)
    (gbt == CTRL_GBT_NO_OVRD && trip_q) |-> guard_cnt_r >= 10'h078)
    else $error("trip without 120 ms guard");
  a_ll_delay: assert property (@(posedge clk) disable iff (!rst_b)
    (ll_dly && ll_ms != 10'h000) |-> ll_cnt_r >= ll_ms)
    else $error("low level output not delayed");

  // window loading and trip/guard release are spelled out as named sequences
  sequence s_loss_onset;
    loc_dly && !loc_d_r && unblk_ms != 10'h000;
  endsequence
  sequence s_window_loaded;
    win_cnt_r == unblk_ms;
  endsequence
  sequence s_trip_release;
    (trip_q_r && th_ms != 10'h000) ##1 !trip_q_r;
  endsequence
  sequence s_guard_release;
    (ind.guard && gh_ms != 10'h000) ##1 !ind.guard;
  endsequence

  a_window_opens: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    s_loss_onset |=> s_window_loaded)
    else $error("unblock window not loaded on loss of channel");
  a_window_counts: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (tick_r && win_cnt_r != 10'h000 && !(loc_dly && !loc_d_r)) |=> win_cnt_r == $past(win_cnt_r) - 10'h001)
    else $error("unblock window not counted down on tick");
  a_window_ends: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (tick_r && win_cnt_r == 10'h001 && !(loc_dly && !loc_d_r)) |=> win_cnt_r == 10'h000)
    else $error("unblock window did not close");
  a_window_shut: assert property (@(posedge clk) disable iff (!rst_b)
    (loc_raw && ll_done && unblk_ms != 10'h000 && win_cnt_r == 10'h000) |-> !trip_q)
    else $error("trip on lost channel outside window");
  a_tick_single: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    tick_r |=> !tick_r)
    else $error("ms tick wider than one cycle");
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> ($stable(out_r) && $stable(tick_cnt_r) && $stable(win_cnt_r)))
    else $error("state moved while clock enable low");
  a_trip_stretch: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    s_trip_release |=> trip_st)
    else $error("trip not stretched after release");
  a_guard_stretch: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    s_guard_release |=> guard_st)
    else $error("guard not stretched after release");
  a_guard_follows: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (gh_ms == 10'h000 && !ind.guard) |=> !guard_st)
    else $error("guard stretched with hold disabled");
  a_dtt_guard_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (direct_transfer_trip_scheme && sw_r.dtt_guard_hold_sel == 2'h1) |-> gh_ms == 10'h00a)
    else $error("transfer trip guard hold decode wrong");
  a_perm_guard_sel: assert property (@(posedge clk) disable iff (!rst_b)
    (!direct_transfer_trip_scheme && sw_r.guard_hold_sel == 2'h1) |-> gh_ms == 10'h00a)
    else $error("permissive guard hold decode wrong");
  a_dtt_trip_long: assert property (@(posedge clk) disable iff (!rst_b)
    (direct_transfer_trip_scheme && sw_r.dtt_trip_hold_sel == 2'h3) |-> th_ms == 10'h064)
    else $error("transfer trip long hold decode wrong");
  a_unblk_short: assert property (@(posedge clk) disable iff (!rst_b)
    (sw_r.unblock_time_sel == 2'h1) |-> unblk_ms == 10'h096)
    else $error("unblock short decode wrong");
  a_unblk_mid: assert property (@(posedge clk) disable iff (!rst_b)
    (sw_r.unblock_time_sel == 2'h2) |-> unblk_ms == 10'h12c)
    else $error("unblock middle decode wrong");
  a_ll_mid: assert property (@(posedge clk) disable iff (!rst_b)
    (sw_r.low_level_delay_sel == 2'h2) |-> ll_ms == 10'h04b)
    else $error("low level middle decode wrong");
  a_ll_short: assert property (@(posedge clk) disable iff (!rst_b)
    (sw_r.low_level_delay_sel == 2'h1) |-> ll_ms == 10'h032)
    else $error("low level short decode wrong");
  a_gbt_ovrd_code: assert property (@(posedge clk) disable iff (!rst_b)
    (sw_r.guard_before_trip_sel == 2'h2) |-> gbt == CTRL_GBT_OVRD)
    else $error("override mode decode wrong");
  a_gbt_off_code: assert property (@(posedge clk) disable iff (!rst_b)
    (sw_r.guard_before_trip_sel == 2'h0) |-> gbt == CTRL_GBT_OFF)
    else $error("guard before trip off decode wrong");
  a_ovrd_long: assert property (@(posedge clk) disable iff (!rst_b)
    (gbt == CTRL_GBT_OVRD && tlong && ind.trip && pre_done
     && (!loc_raw || unblk_ms == 10'h000 || win_open || !ll_done)) |-> trip_q)
    else $error("long trip not let through by override");
  a_pre_clears: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    !ind.trip |=> pre_cnt_r == 10'h000)
    else $error("pretrip count kept after trip dropped");
  a_tlong_clears: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    !ind.trip |=> tlong_cnt_r == 10'h000)
    else $error("long trip count kept after trip dropped");
  a_guard_clears: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (!ind.guard && !ind.trip) |=> guard_cnt_r == 10'h000)
    else $error("guard count kept with guard and trip absent");
  a_ll_follows: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (ll_ms == 10'h000) |=> ll_q_r == $past(ind.low_level))
    else $error("low level not passed with delay disabled");
  a_ll_early: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    (ind.low_level && !ll_done) |=> !ll_q_r)
    else $error("low level passed before delay");
endmodule
`default_nettype wire

// >>> rtl/ctrl_pkg.sv
// ctrl_pkg: constants, modes and carriers for the carrier trip receiver logic
// assumes a 200 MHz system clock; all timers count a 1 ms tick
package ctrl_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int          MS_W          = 10;
  localparam logic [9:0]  PRETRIP_STEP_MS = 10'h002;
  localparam logic [9:0]  HOLD_10_MS    = 10'h00a;
  localparam logic [9:0]  HOLD_50_MS    = 10'h032;
  localparam logic [9:0]  HOLD_100_MS   = 10'h064;
  localparam logic [9:0]  UNBLK_150_MS  = 10'h096;
  localparam logic [9:0]  UNBLK_300_MS  = 10'h12c;
  localparam logic [9:0]  UNBLK_500_MS  = 10'h1f4;
  localparam logic [9:0]  LOWLVL_50_MS  = 10'h032;
  localparam logic [9:0]  LOWLVL_75_MS  = 10'h04b;
  localparam logic [9:0]  LOWLVL_100_MS = 10'h064;
  localparam logic [9:0]  GBT_GUARD_MS  = 10'h078;
  localparam logic [9:0]  GBT_OVRD_MS   = 10'h3e8;
  localparam int          SEL_HOLD_LSB  = 0;
  localparam int          SEL_HOLD_MSB  = 1;

  typedef enum logic [1:0] {CTRL_GBT_OFF, CTRL_GBT_NO_OVRD, CTRL_GBT_OVRD} ctrl_gbt_e;

  // discriminator indications
  typedef struct packed {
    logic trip;
    logic guard;
    logic low_level;
    logic noise;
  } ctrl_ind_s;

  // switch image; a bit is 1 when the switch is closed
  typedef struct packed {
    logic       dtt_scheme;          // direct_transfer_trip_scheme program
    logic [3:0] pretrip;             // permissive_overreach_scheme / unblock_scheme pretrip
    logic [1:0] trip_hold_sel;       // {b,a}
    logic [1:0] guard_hold_sel;
    logic [1:0] unblock_time_sel;
    logic       noise_block_sel;
    logic [1:0] guard_before_trip_sel;
    logic [3:0] dtt_pretrip;         // bit3..bit0
    logic [1:0] dtt_trip_hold_sel;
    logic [1:0] dtt_guard_hold_sel;
    logic       reserved_closed_switch;
    logic [1:0] low_level_delay_sel;
  } ctrl_sw_s;

  typedef struct packed {
    logic trip;
    logic guard;
    logic low_level;
  } ctrl_out_s;
endpackage

// >>> rtl/ctrl_stretch.sv
// ctrl_stretch: holds an output high for a set number of ms after its input drops
// assumes tick is a one-cycle pulse every ms and len is static
`timescale 1ns/1ps
`default_nettype none
module ctrl_stretch
  import ctrl_pkg::*;
#(
  parameter int W = MS_W
)(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic         tick,
  input  wire logic         in,
  input  wire logic [W-1:0] len,
  output logic              out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         out_nxt;

  // zero length passes the input straight through one flop
  assign cnt_nxt = in ? len : ((tick && cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign out_nxt = in || (cnt_nxt != '0 && len != '0);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      out   <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      out   <= out_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> bench/ctrl_disc_model.sv
// ctrl_disc_model: discriminator stand-in that presents the indication levels
// assumes the bench sets want; levels only move on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module ctrl_disc_model
  import ctrl_pkg::*;
(
  input  wire logic      clk,
  input  wire ctrl_ind_s want,
  output var  ctrl_ind_s ind
);
  always @(negedge clk)
  begin
    ind <= want;
  end
endmodule
`default_nettype wire

// >>> bench/ctrl_rx_logic_test.sv
// ctrl_rx_logic_test: directed checks of trip, guard and low-level qualification
// assumes a 10-cycle ms tick so the long timers stay cheap to run
`timescale 1ns/1ps
`default_nettype none
module ctrl_rx_logic_test
  import ctrl_pkg::*;
;
  localparam int T = 10;
  logic      clk = 1'b0;
  logic      rst_b = 1'b0;
  logic      ce = 1'b1;
  ctrl_sw_s  sw = '0;
  ctrl_sw_s  s;
  ctrl_ind_s want = '0;
  ctrl_ind_s ind;
  ctrl_out_s out;
  int        bad_count = 0;
  int        compares = 0;
  int        hold_t[4] = '{0, 10, 50, 100};
  int        ll_t[4] = '{0, 50, 75, 100};
  int        unblk_t[4] = '{0, 150, 300, 500};

  always #2.5 clk = ~clk;

  ctrl_disc_model disc (.clk(clk), .want(want), .ind(ind));
  ctrl_rx_logic #(.TICK_CYCLES(T)) dut (.clk(clk), .rst_b(rst_b), .ce(ce), .ind(ind), .sw(sw), .out(out));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input string what, input logic seen, input logic exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask

  // wait m ms, then look at the trip output
  task automatic tck(input int m, input logic e);
    cyc(m * T);
    chk("trip", out.trip, e);
  endtask

  task automatic restart();
    want = '0;
    sw = s;
    rst_b = 1'b0;
    cyc(4);
    rst_b = 1'b1;
    cyc(2);
  endtask

  task automatic base();
    s = '0;
    s.reserved_closed_switch = 1'b1;
  endtask

  // cycles from raising trip until out.trip; bounded by hi
  task automatic trip_at(input int lo, input int hi);
    int n;
    n = 0;
    want = 4'h8;
    while (out.trip !== 1'b1 && n <= hi)
    begin
      cyc(1);
      n++;
    end
    chk("trip delay", n >= lo && n <= hi, 1'b1);
    if (n > hi)
      conclude();
    want = '0;
    cyc(3 * T);
  endtask

  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    // wrong-program fields get a different code so a bad select shows
    for (int d = 0; d < 2; d++)
      for (int i = 0; i < 4; i++)
      begin
        base();
        s.dtt_scheme = d[0];
        s.trip_hold_sel = 2'(d ? 3 - i : i);
        s.guard_hold_sel = 2'(d ? 3 - i : i);
        s.dtt_trip_hold_sel = 2'(d ? i : 3 - i);
        s.dtt_guard_hold_sel = 2'(d ? i : 3 - i);
        restart();
        want = 4'hc;
        cyc(4 * T);
        want = '0;
        cyc(i > 0 ? (hold_t[i] - 2) * T : 1);
        chk("trip held", out.trip, 1'b1);
        chk("guard held", out.guard, 1'b1);
        cyc(i > 0 ? 3 * T : T);
        chk("trip ended", out.trip, 1'b0);
        chk("guard ended", out.guard, 1'b0);
      end
    base();
    s.pretrip = 4'h7;
    restart();
    want = 4'h8;
    tck(10, 1'b0);
    // clock enable low freezes the pretrip count short of its end
    ce = 1'b0;
    tck(20, 1'b0);
    ce = 1'b1;
    tck(6, 1'b1);
    want = '0;
    cyc(3 * T);
    trip_at(13 * T, 14 * T + 6);
    s.pretrip = 4'h0;
    restart();
    trip_at(1, 6);
    s.dtt_scheme = 1'b1;
    restart();
    trip_at(T, 2 * T + 6);
    s.dtt_pretrip = 4'hf;
    restart();
    trip_at(29 * T, 30 * T + 6);
    for (int i = 0; i < 4; i++)
    begin
      base();
      s.low_level_delay_sel = 2'(i);
      restart();
      want = 4'h2;
      cyc(i > 0 ? (ll_t[i] - 2) * T : 1);
      chk("low level early", out.low_level, 1'b0);
      cyc(i > 0 ? 3 * T : T);
      chk("low level", out.low_level, 1'b1);
    end
    // loss of channel: trip only inside the window
    for (int i = 1; i < 4; i++)
    begin
      base();
      s.unblock_time_sel = 2'(i);
      restart();
      want = 4'ha;
      tck(unblk_t[i] - 3, 1'b1);
      tck(4, 1'b0);
    end
    base();
    s.unblock_time_sel = 2'b01;
    s.noise_block_sel = 1'b1;
    restart();
    want = 4'hb;
    tck(5, 1'b0);
    s.noise_block_sel = 1'b0;
    restart();
    want = 4'hb;
    tck(5, 1'b1);
    s.low_level_delay_sel = 2'b01;
    restart();
    want = 4'ha;
    tck(195, 1'b1);
    tck(10, 1'b0);
    base();
    s.guard_before_trip_sel = 2'b01;
    restart();
    want = 4'h8;
    tck(20, 1'b0);
    want = '0;
    cyc(2 * T);
    want = 4'h4;
    cyc(100 * T);
    want = 4'h8;
    tck(3, 1'b0);
    want = '0;
    cyc(2 * T);
    want = 4'h4;
    cyc(125 * T);
    want = 4'h8;
    tck(3, 1'b1);
    restart();
    want = 4'ha;
    tck(5, 1'b0);
    s.guard_before_trip_sel = 2'b10;
    restart();
    want = 4'ha;
    tck(5, 1'b1);
    restart();
    want = 4'h8;
    tck(990, 1'b0);
    tck(15, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
